/* File: core/pbs_pkg.sv */
// Types shared by the pushbutton power sequencer.
`default_nettype none
package pbs_pkg;
    typedef enum logic [2:0] {
        PBS_IDLE = 3'b000,
        PBS_ON_DEB = 3'b001,
        PBS_BLANK = 3'b011,
        PBS_REL_ON = 3'b010,
        PBS_RUN = 3'b110,
        PBS_OFF_DEB = 3'b111,
        PBS_KILL_WAIT = 3'b101,
        PBS_LOCKOUT = 3'b100
    } pbs_state_t;
endpackage : pbs_pkg
`default_nettype wire

/* File: core/pbs_regs.svh */
// Timing constants of the pushbutton power sequencer.
`ifndef PBS_REGS_SVH
`define PBS_REGS_SVH
`define PBS_CLK_HZ 20000000
`define PBS_TURN_ON_DEBOUNCE_MS 128
`define PBS_POWER_ON_BLANK_MS 512
`define PBS_TURN_OFF_DEBOUNCE_MS 32
`define PBS_RELEASE_DEBOUNCE_MS 32
`define PBS_KILL_TIMEOUT_MS 128
`define PBS_RESTART_LOCKOUT_MS 256
`define PBS_KILL_MIN_PULSE_US 30
`define PBS_TICK_US 1000
`define PBS_CYC_PER_TICK (`PBS_CLK_HZ / 1000000 * `PBS_TICK_US)
`define PBS_KILL_FILT_CYC ((`PBS_CLK_HZ / 1000000) * `PBS_KILL_MIN_PULSE_US)
`define PBS_MS_W 16
`define PBS_CYC_W 16
`endif

/* File: core/pbs_sequencer.sv */
// Pushbutton on/off power sequencer with host shutdown handshake.
//
// Summary of operation
// - Reset leaves supply enable off.
// - Off: enable after 128 ms button low.
// - Button high restarts turn-on debounce.
// - Enable starts 512 ms blank, kill ignored.
// - Button not sampled during blanking.
// - Kill low at blank end aborts.
// - After blank, debounce release 32 ms.
// - On: off after 32 ms plus extension.
// - Button high restarts turn-off debounce.
// - Debounce done drives shutdown request low.
// - Request starts 128 ms plus delay timeout.
// - Kill during timeout disables at once.
// - Kill low while on disables immediately.
// - After off, 256 ms button lockout.
// - After off, debounce release 32 ms.
// - Then idle, awaiting new press.
// - Enable polarity set by parameter.
// - Kill low under 30 us ignored.
`include "pbs_regs.svh"
`default_nettype none
module pbs_sequencer #(
    // Clock cycles per timer tick; a smaller value only shortens simulation.
    parameter int CYC_PER_TICK = `PBS_CYC_PER_TICK,
    parameter bit ENABLE_ACTIVE_HIGH = 1'b1,
    parameter logic [`PBS_MS_W-1:0] OFF_DEBOUNCE_EXTEND = '0,
    parameter logic [`PBS_MS_W-1:0] KILL_DELAY_EXTEND = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic button_n,
    input wire logic kill_n,
    output logic supply_enable,
    output logic shutdown_req_n,
    output logic shutdown_req_n_oe,
    output pbs_pkg::pbs_state_t seq_state
);
    import pbs_pkg::*;

    // ****************************************
    // Time constants in ticks, kill filter in clock cycles
    // ****************************************
    localparam logic [`PBS_MS_W-1:0] ON_DEB = `PBS_MS_W'(`PBS_TURN_ON_DEBOUNCE_MS);
    localparam logic [`PBS_MS_W-1:0] BLANK = `PBS_MS_W'(`PBS_POWER_ON_BLANK_MS);
    localparam logic [`PBS_MS_W-1:0] REL = `PBS_MS_W'(`PBS_RELEASE_DEBOUNCE_MS);
    localparam logic [`PBS_MS_W-1:0] LOCK = `PBS_MS_W'(`PBS_RESTART_LOCKOUT_MS);
    localparam logic [`PBS_MS_W-1:0] OFF_DEB =
        `PBS_MS_W'(`PBS_TURN_OFF_DEBOUNCE_MS) + OFF_DEBOUNCE_EXTEND;
    localparam logic [`PBS_MS_W-1:0] KILL_TO =
        `PBS_MS_W'(`PBS_KILL_TIMEOUT_MS) + KILL_DELAY_EXTEND;
    localparam logic [`PBS_CYC_W-1:0] KILL_FILT = `PBS_CYC_W'(`PBS_KILL_FILT_CYC);

    // ****************************************
    // Input synchronisers and time base
    // ****************************************
    logic button_s;
    logic kill_s;
    logic tick;

    pbs_sync u_sync_button (
        .clk(clk),
        .rst(rst),
        .async_in(button_n),
        .sync_out(button_s)
    );
    pbs_sync u_sync_kill (
        .clk(clk),
        .rst(rst),
        .async_in(kill_n),
        .sync_out(kill_s)
    );
    pbs_tick #(
        .CYC_PER_TICK(CYC_PER_TICK)
    ) u_tick (
        .clk(clk),
        .rst(rst),
        .tick(tick)
    );

    // ****************************************
    // Kill glitch filter
    // ****************************************
    // The filtered kill level falls only after 30 us of continuous low, and
    // rises at once, so a short dip never ends a run.
    logic [`PBS_CYC_W-1:0] kill_cnt;
    logic [`PBS_CYC_W-1:0] next_kill_cnt;
    logic kill_low;
    logic next_kill_low;

    always_comb begin
        next_kill_cnt = kill_cnt;
        next_kill_low = kill_low;
        if (kill_s) begin
            next_kill_cnt = '0;
            next_kill_low = 1'b0;
        end else if (kill_cnt >= KILL_FILT - `PBS_CYC_W'(1)) begin
            next_kill_low = 1'b1;
        end else begin
            next_kill_cnt = kill_cnt + `PBS_CYC_W'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            kill_cnt <= '0;
            kill_low <= 1'b0;
        end else begin
            kill_cnt <= next_kill_cnt;
            kill_low <= next_kill_low;
        end
    end

    // ****************************************
    // Sequencer state machine
    // ****************************************
    pbs_state_t state;
    pbs_state_t next_state;
    logic [`PBS_MS_W-1:0] ms;
    logic [`PBS_MS_W-1:0] next_ms;
    logic en_on;
    logic next_en_on;
    logic req;
    logic next_req;
    logic [`PBS_MS_W-1:0] ms_inc;

    assign ms_inc = tick ? ms + `PBS_MS_W'(1) : ms;

    always_comb begin
        next_state = state;
        next_ms = ms_inc;
        next_en_on = en_on;
        next_req = req;
        unique case (state)
            PBS_IDLE: begin
                next_ms = '0;
                if (!button_s) begin
                    next_state = PBS_ON_DEB;
                end
            end
            PBS_ON_DEB: begin
                if (button_s) begin
                    next_state = PBS_IDLE;
                    next_ms = '0;
                // The tick phase is free, so one extra tick keeps the turn-on/turn-off debounce, blank and timeout spans a minimum.
                end else if (ms_inc > ON_DEB) begin
                    next_state = PBS_BLANK;
                    next_en_on = 1'b1;
                    next_ms = '0;
                end
            end
            PBS_BLANK: begin
                // Neither input is looked at until the window ends.
                if (ms_inc > BLANK) begin
                    next_ms = '0;
                    if (kill_low) begin
                        next_state = PBS_LOCKOUT;
                        next_en_on = 1'b0;
                    end else begin
                        next_state = PBS_REL_ON;
                    end
                end
            end
            PBS_REL_ON: begin
                if (kill_low) begin
                    next_state = PBS_LOCKOUT;
                    next_en_on = 1'b0;
                    next_ms = '0;
                end else if (!button_s) begin
                    next_ms = '0;
                end else if (ms_inc >= REL) begin
                    next_state = PBS_RUN;
                    next_ms = '0;
                end
            end
            PBS_RUN: begin
                next_ms = '0;
                if (kill_low) begin
                    next_state = PBS_LOCKOUT;
                    next_en_on = 1'b0;
                end else if (!button_s) begin
                    next_state = PBS_OFF_DEB;
                end
            end
            PBS_OFF_DEB: begin
                if (kill_low) begin
                    next_state = PBS_LOCKOUT;
                    next_en_on = 1'b0;
                    next_ms = '0;
                end else if (button_s) begin
                    next_state = PBS_RUN;
                    next_ms = '0;
                end else if (ms_inc > OFF_DEB) begin
                    next_state = PBS_KILL_WAIT;
                    next_req = 1'b1;
                    next_ms = '0;
                end
            end
            PBS_KILL_WAIT: begin
                if (kill_low || ms_inc > KILL_TO) begin
                    next_state = PBS_LOCKOUT;
                    next_en_on = 1'b0;
                    next_req = 1'b0;
                    next_ms = '0;
                end
            end
            PBS_LOCKOUT: begin
                // The lockout runs first; the release debounce then needs the
                // button high for a further 32 ms before a new press counts.
                if (ms < LOCK) begin
                    next_ms = ms_inc;
                end else if (!button_s) begin
                    next_ms = LOCK;
                end else if (ms_inc >= LOCK + REL) begin
                    next_state = PBS_IDLE;
                    next_ms = '0;
                end
            end
        endcase
        if (!next_en_on) begin
            next_req = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= PBS_IDLE;
            ms <= '0;
            en_on <= 1'b0;
            req <= 1'b0;
        end else begin
            state <= next_state;
            ms <= next_ms;
            en_on <= next_en_on;
            req <= next_req;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Polarity is the only variant difference.
    assign supply_enable = ENABLE_ACTIVE_HIGH ? en_on : ~en_on;
    assign shutdown_req_n = ~req;
    assign shutdown_req_n_oe = req;
    assign seq_state = state;

    // ****************************************
    // Assertions
    // ****************************************
    a_reset_off: assert property (@(posedge clk) rst |=> !en_on)
        else $error("enable not off after reset");
    a_on_needs_press: assert property (@(posedge clk) disable iff (rst)
        $rose(en_on) |-> $past(state) == PBS_ON_DEB && $past(button_s)==1'b0)
        else $error("enable rose without a debounced press");
    a_on_bounce: assert property (@(posedge clk) disable iff (rst)
        state == PBS_ON_DEB && button_s |=> state == PBS_IDLE)
        else $error("turn-on debounce not restarted");
    a_blank_hold: assert property (@(posedge clk) disable iff (rst)
        state == PBS_BLANK && ms_inc <= BLANK |=> en_on && state == PBS_BLANK)
        else $error("blanking window broken early");
    a_abort: assert property (@(posedge clk) disable iff (rst)
        state == PBS_BLANK && ms_inc > BLANK && kill_low |=> !en_on)
        else $error("power-on not aborted");
    a_kill_off: assert property (@(posedge clk) disable iff (rst)
        kill_low && state inside {PBS_RUN, PBS_OFF_DEB, PBS_KILL_WAIT, PBS_REL_ON}
        |=> !en_on && !req)
        else $error("kill did not drop enable");
    a_req_flow: assert property (@(posedge clk) disable iff (rst)
        $rose(req) |-> $past(state) == PBS_OFF_DEB && en_on)
        else $error("request raised out of sequence");
    a_req_with_en: assert property (@(posedge clk) disable iff (rst)
        req |-> en_on)
        else $error("request held without enable");
    a_lockout: assert property (@(posedge clk) disable iff (rst)
        $fell(en_on) |=> state == PBS_LOCKOUT [*8])
        else $error("lockout not entered");
    a_off_bounce: assert property (@(posedge clk) disable iff (rst)
        state == PBS_OFF_DEB && button_s && !kill_low |=> state == PBS_RUN)
        else $error("turn-off debounce not restarted");

    // ****************************************
    // Timing assertions
    // ****************************************
    // Each span is checked as a minimum against the state timer, the kill filter against its own cycle counter.
    a_idle_off: assert property (@(posedge clk) disable iff (rst)
        state == PBS_IDLE |-> !en_on && !req)
        else $error("enable or request on while idle");
    a_on_deb_off: assert property (@(posedge clk) disable iff (rst)
        state == PBS_ON_DEB |-> !en_on)
        else $error("enable on during turn-on debounce");
    a_on_min_time: assert property (@(posedge clk) disable iff (rst)
        $rose(en_on) |-> $past(ms) >= ON_DEB)
        else $error("turn-on debounce too short");
    a_blank_start: assert property (@(posedge clk) disable iff (rst)
        $rose(en_on) |-> state == PBS_BLANK && ms == '0)
        else $error("blanking not started with enable");

    a_blank_kill: assert property (@(posedge clk) disable iff (rst)
        state == PBS_BLANK && ms_inc <= BLANK && kill_low |=> en_on)
        else $error("kill acted during blanking");
    a_blank_button: assert property (@(posedge clk) disable iff (rst)
        state == PBS_BLANK && ms_inc <= BLANK && !button_s |=> state == PBS_BLANK)
        else $error("button acted during blanking");
    a_rel_restart: assert property (@(posedge clk) disable iff (rst)
        state == PBS_REL_ON && !button_s && !kill_low |=> state == PBS_REL_ON && ms == '0)
        else $error("release debounce not restarted");
    a_run_entry: assert property (@(posedge clk) disable iff (rst)
        state == PBS_RUN && $past(state) == PBS_REL_ON |-> $past(ms_inc) >= REL)
        else $error("run entered before release debounce");

    a_req_min_time: assert property (@(posedge clk) disable iff (rst)
        $rose(req) |-> $past(ms) >= OFF_DEB)
        else $error("turn-off debounce too short");
    a_kill_wait_on: assert property (@(posedge clk) disable iff (rst)
        state == PBS_KILL_WAIT |-> req && en_on)
        else $error("kill wait without request");
    a_kill_wait_hold: assert property (@(posedge clk) disable iff (rst)
        state == PBS_KILL_WAIT && ms_inc <= KILL_TO && !kill_low |=> state == PBS_KILL_WAIT)
        else $error("kill timeout ended early");
    a_timeout: assert property (@(posedge clk) disable iff (rst)
        state == PBS_KILL_WAIT && ms_inc > KILL_TO |=> state == PBS_LOCKOUT && !en_on)
        else $error("kill timeout did not drop enable");

    a_lock_hold: assert property (@(posedge clk) disable iff (rst)
        state == PBS_LOCKOUT && ms < LOCK |=> state == PBS_LOCKOUT && !en_on)
        else $error("lockout left early");
    a_lock_release: assert property (@(posedge clk) disable iff (rst)
        state == PBS_LOCKOUT && ms >= LOCK && !button_s |=> state == PBS_LOCKOUT && ms == LOCK)
        else $error("release debounce not restarted after off");
    a_lock_exit: assert property (@(posedge clk) disable iff (rst)
        state == PBS_IDLE && $past(state) == PBS_LOCKOUT |-> $past(ms_inc) >= LOCK + REL)
        else $error("idle entered before lockout and release");

    a_glitch_drop: assert property (@(posedge clk) disable iff (rst)
        kill_s |=> !kill_low)
        else $error("filtered kill not cleared by high input");
    a_kill_min: assert property (@(posedge clk) disable iff (rst)
        $rose(kill_low) |-> kill_cnt == KILL_FILT - `PBS_CYC_W'(1))
        else $error("kill accepted before minimum width");
endmodule : pbs_sequencer
`default_nettype wire

/* File: core/pbs_sync.sv */
// Two-flop synchroniser for an asynchronous input level.
`default_nettype none
module pbs_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic async_in,
    output logic sync_out
);
    logic stage1;
    logic next_stage1;
    logic next_sync_out;

    always_comb begin
        next_stage1 = async_in;
        next_sync_out = stage1;
    end

    // Resets high: both inputs idle high, so no false press at start-up.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1 <= 1'b1;
            sync_out <= 1'b1;
        end else begin
            stage1 <= next_stage1;
            sync_out <= next_sync_out;
        end
    end
endmodule : pbs_sync
`default_nettype wire

/* File: core/pbs_tick.sv */
// Millisecond time base for the sequencer state timers; the kill filter counts clock cycles.
`include "pbs_regs.svh"
`default_nettype none
module pbs_tick #(
    parameter int CYC_PER_TICK = `PBS_CYC_PER_TICK
) (
    input wire logic clk,
    input wire logic rst,
    output logic tick
);
    localparam logic [`PBS_CYC_W-1:0] LAST = `PBS_CYC_W'(CYC_PER_TICK - 1);
    logic [`PBS_CYC_W-1:0] count;
    logic [`PBS_CYC_W-1:0] next_count;
    logic next_tick;

    always_comb begin
        next_tick = (count == LAST);
        next_count = next_tick ? '0 : count + `PBS_CYC_W'(1);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= '0;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end
endmodule : pbs_tick
`default_nettype wire

/* File: tb/pbs_host_model.sv */
// Behavioural host processor that answers the sequencer's kill handshake.
`default_nettype none
module pbs_host_model #(
    parameter int TICK = 20000
) (
    input wire logic clk,
    input wire logic supply_enable,
    input wire logic req_line,
    input wire logic [15:0] raise_ms,
    input wire logic [15:0] ack_ms,
    input wire logic glitch_go,
    output logic kill_n
);
    timeunit 1ns;
    timeprecision 1ns;
    int unsigned on_cnt = 0;
    int unsigned req_cnt = 0;
    int unsigned gl = 0;
    logic raised;
    logic acked;
    initial kill_n = 1'b0;
    // An unpowered host cannot hold kill high, so it reads low while off.
    assign raised = supply_enable && raise_ms != 0 && on_cnt >= raise_ms * TICK;
    assign acked = ack_ms != 0 && req_cnt >= ack_ms * TICK;
    always @(posedge clk) begin
        on_cnt <= supply_enable ? on_cnt + 1 : 0;
        req_cnt <= !req_line ? req_cnt + 1 : 0;
        gl <= glitch_go ? 400 : (gl != 0 ? gl - 1 : 0);
        kill_n <= #1 raised && !acked && gl == 0;
    end
endmodule : pbs_host_model
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking testbench of the pushbutton power sequencer.
`default_nettype none
module tb_top;
    import pbs_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic button_n = 1'b1;
    logic kill_n;
    logic supply_enable;
    logic shutdown_req_n;
    logic shutdown_req_n_oe;
    logic req_line;
    pbs_state_t seq_state;
    logic [15:0] raise_ms = 16'h0;
    logic [15:0] ack_ms = 16'h0;
    logic glitch_go = 1'b0;
    int fails = 0;
    int n_checks = 0;
    int seed = 63168;
    int c;
    // Shortened tick keeps the run short; the kill filter stays at real cycles.
    localparam int TICK = 20;
    localparam int KILL_FILT_CYC = 600;
    // Open-drain request line with its pull-up.
    assign req_line = shutdown_req_n_oe ? shutdown_req_n : 1'b1;
    initial begin
        forever #25 clk = ~clk;
    end
    pbs_sequencer #(.CYC_PER_TICK(TICK)) pbs_sequencer_inst (.clk(clk), .rst(rst),
        .button_n(button_n),
        .kill_n(kill_n), .supply_enable(supply_enable), .shutdown_req_n(shutdown_req_n),
        .shutdown_req_n_oe(shutdown_req_n_oe), .seq_state(seq_state));
    pbs_host_model #(.TICK(TICK)) pbs_host_model_inst (.clk(clk), .supply_enable(supply_enable),
        .req_line(req_line), .raise_ms(raise_ms), .ack_ms(ack_ms), .glitch_go(glitch_go),
        .kill_n(kill_n));
    // ****************************************
    // Helpers
    // ****************************************
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    task automatic bad(input string msg);
        fails++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask : bad
    task automatic chk(input logic [2:0] got, input logic [2:0] exp, input string msg);
        n_checks++;
        if (got !== exp) bad(msg);
    endtask : chk
    function automatic int cyc(input int ms);
        return ms * TICK;
    endfunction : cyc
    // Timers run on a free ms tick, so a span may overrun by one tick plus sync delay.
    task automatic win(input int got, input int ms, input string msg);
        n_checks++;
        if (got < cyc(ms) || got > cyc(ms + 1) + 20) bad(msg);
    endtask : win
    task automatic push(input logic v);
        @(posedge clk);
        #1 button_n = v;
    endtask : push
    task automatic hold(input int ms);
        repeat (cyc(ms)) @(posedge clk);
    endtask : hold
    task automatic wait_lvl(input bit sel, input logic v, input int ms, output int n);
        n = 0;
        while ((sel ? req_line : supply_enable) !== v) begin
            @(posedge clk);
            #1 n++;
            if (n > cyc(ms)) begin
                bad("wait limit");
                print_verdict();
            end
        end
    endtask : wait_lvl
    task automatic stay(input logic v, input int ms, input string msg);
        n_checks++;
        for (int i = 0; i < cyc(ms); i++) begin
            @(posedge clk);
            #1;
            if (supply_enable !== v) begin
                bad(msg);
                break;
            end
        end
    endtask : stay
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        chk({2'h0, supply_enable}, 3'h0, "enable after reset");
        chk({2'h0, req_line}, 3'h1, "request after reset");
        raise_ms = 16'h1 + 16'($random(seed) & 255);
        push(1'b0);
        hold(100 + ($random(seed) & 15));
        push(1'b1);
        hold(2);
        push(1'b0);
        wait_lvl(1'b0, 1'b1, 140, c);
        win(c, 128, "turn-on debounce");
        stay(1'b1, 600, "held button or kill in blank");
        push(1'b1);
        hold(40);
        chk(seq_state, PBS_RUN, "run after release");
        push(1'b0);
        wait_lvl(1'b1, 1'b0, 40, c);
        win(c, 32, "turn-off debounce");
        push(1'b1);
        wait_lvl(1'b0, 1'b0, 140, c);
        win(c, 128, "kill timeout");
        chk({2'h0, req_line}, 3'h1, "request released");
        push(1'b0);
        stay(1'b0, 300, "press during lockout");
        push(1'b1);
        hold(40);
        chk(seq_state, PBS_IDLE, "idle after release");
        ack_ms = 16'h5;
        push(1'b0);
        wait_lvl(1'b0, 1'b1, 140, c);
        push(1'b1);
        hold(560);
        @(posedge clk);
        #1 glitch_go = 1'b1;
        @(posedge clk);
        #1 glitch_go = 1'b0;
        stay(1'b1, 40, "short kill pulse");
        push(1'b0);
        wait_lvl(1'b1, 1'b0, 40, c);
        push(1'b1);
        wait_lvl(1'b0, 1'b0, 140, c);
        n_checks++;
        if (c < cyc(5) + KILL_FILT_CYC || c > cyc(5) + KILL_FILT_CYC + 10) begin
            bad("host kill during timeout");
        end
        chk({2'h0, req_line}, 3'h1, "request released by kill");
        hold(300);
        raise_ms = 16'h0;
        push(1'b0);
        wait_lvl(1'b0, 1'b1, 140, c);
        push(1'b1);
        wait_lvl(1'b0, 1'b0, 520, c);
        win(c, 512, "aborted power-on");
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
